//--- pkg/lrp_pkg.sv
/*
  lrp_pkg: constants and types shared by the LED driver serial register port.
  Assumes a 100 MHz system clock and a serial clock of at most 400 kHz.
*/
package lrp_pkg;

  // ----------------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] BIT_MSB = 3'h7;

  // ----------------------------------------------------------------------
  // register space and address selection
  // ----------------------------------------------------------------------
  localparam int PTR_W = 6;
  localparam int REG_NUM = 64;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h48;
  localparam logic [PTR_W-1:0] CTRL_ADDR = 6'h00;
  localparam int PDEN_BIT = 3;
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SCL_LOW_US = 350;
  localparam int SCL_LOW_CYC = SCL_LOW_US * CLK_MHZ;
  localparam int LOW_CNT_W = 16;
  localparam int SYNC_W = 5;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } lrp_state_t;

  typedef struct packed {
    logic valid;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } lrp_reg_wr_t;

endpackage : lrp_pkg

//--- design/lrp_link_cap.sv
/*
  lrp_link_cap: serial clock domain capture of the data line.
  Assumes the data line is stable while the serial clock is high, so a
  rising edge sample needs no synchroniser; the toggle is synchronised by
  the reader, and the bit is held until the next serial clock rise.
*/
`timescale 1ns/1ps
`default_nettype none

module lrp_link_cap (
  // link clock and reset
  input wire logic scl_clk,
  input wire logic rst_b,
  // data pin
  input wire logic sda_in,
  // captured bit and its event toggle
  output logic bit_val,
  output logic bit_tog
);

  // ----------------------------------------------------------------------
  // sample on every serial clock rise
  // ----------------------------------------------------------------------
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_val <= 1'b0;
      // matches the reader's synchroniser reset, so no false bit event
      bit_tog <= 1'b1;
    end else begin
      bit_val <= sda_in; // RQ1
      bit_tog <= ~bit_tog;
    end
  end

endmodule : lrp_link_cap

`default_nettype wire

//--- design/lrp_regmem.sv
/*
  lrp_regmem: 64 by 8 register store of the LED driver.
  Assumes one write port from the serial engine; read data are registered
  and follow the read address one clock later.
*/
`timescale 1ns/1ps
`default_nettype none

module lrp_regmem
  import lrp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // write port
  input wire lrp_pkg::lrp_reg_wr_t wr,
  // read port
  input wire logic [lrp_pkg::PTR_W-1:0] rd_addr,
  output logic [lrp_pkg::BYTE_W-1:0] rd_data
);

  logic [BYTE_W-1:0] mem [REG_NUM];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_NUM; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (wr.valid) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // ----------------------------------------------------------------------
  // registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= REG_RESET;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : lrp_regmem

`default_nettype wire

//--- design/lrp_port.sv
/*
  lrp_port: two-wire serial target port of a nine channel LED driver.
  Assumes open-drain lines with external pull-ups, a 100 MHz system clock
  and a serial clock of at most 400 kHz that also clocks the capture stage.
*/
// Functional notes
// RQ1 - The data line only changes while the serial clock is low.
// RQ2 - Data falling while the clock is high is a start or repeated start.
// RQ3 - Data rising while the clock is high is a stop ending the transfer.
// RQ4 - Bytes are eight bits, most significant first, then one ack slot.
// RQ5 - The device pulls data low in the ack slot of each accepted byte.
// RQ6 - On a read the host gives a not-acknowledge after the data byte.
// RQ7 - Bit rates up to 400 kbit/s work, and the host stays within it.
// RQ8 - The strap picks the address pair 90H/91H, 92H/93H, 94H/95H, 96H/97H.
// RQ9 - The first byte is seven address bits and a direction bit, 0 write.
// RQ10 - The pointer byte's low six bits pick the start register.
// RQ11 - Burst writes store bytes at consecutive registers until stop.
// RQ12 - A single write stores one byte and is then ended by the host.
// RQ13 - Reads use pointer write, repeated start, read address, data out.
// RQ14 - With the enable bit set, clock low over 350 us enters shutdown.
// RQ15 - A transfer with a foreign address is ignored until the next start.
// RQ16 - Both lines are open-drain and are only ever pulled low.
`timescale 1ns/1ps
`default_nettype none

module lrp_port
  import lrp_pkg::*;
#(
  parameter int unsigned SHDN_CYC = lrp_pkg::SCL_LOW_CYC
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial link
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // address strap, already decoded: 0 gnd, 1 clock, 2 data, 3 supply
  input wire logic [1:0] addr_strap,
  // register write stream to the LED core
  output lrp_pkg::lrp_reg_wr_t reg_wr,
  // power state
  output logic shutdown
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic tog_s;
  logic [1:0] strap_s;
  logic scl_p;
  logic sda_p;
  logic tog_p;
  logic start;
  logic stop;
  logic scl_fall;
  logic bit_evt;
  logic link_bit;
  logic link_tog;
  lrp_state_t state;
  logic [3:0] cnt;
  logic [BYTE_W-1:0] shift;
  logic [BYTE_W-1:0] byte_in;
  logic ack_now;
  logic rw;
  logic [PTR_W-1:0] ptr;
  logic [BYTE_W-1:0] rd_data;
  logic [6:0] own_addr;
  logic [1:0] strap_cnt;
  logic pden;
  logic [LOW_CNT_W-1:0] low_cnt;
  logic byte_done;
  logic slot_done;

  // ----------------------------------------------------------------------
  // link capture and register store
  // ----------------------------------------------------------------------
  lrp_link_cap u_cap (
    .scl_clk(scl_clk),
    .rst_b(rst_b),
    .sda_in(sda_i),
    .bit_val(link_bit),
    .bit_tog(link_tog)
  );

  lrp_regmem u_mem (
    .clock(clock),
    .rst_b(rst_b),
    .wr(reg_wr),
    .rd_addr(ptr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------------
  // pin and toggle synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_meta <= '1;
      sync_q <= '1;
    end else begin
      sync_meta <= {addr_strap, link_tog, sda_i, scl_clk}; // RQ7
      sync_q <= sync_meta;
    end
  end

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign tog_s = sync_q[2];
  assign strap_s = sync_q[4:3];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      tog_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      tog_p <= tog_s;
    end
  end

  // ----------------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------------
  assign start = scl_s & scl_p & sda_p & ~sda_s; // RQ2
  assign stop = scl_s & scl_p & ~sda_p & sda_s; // RQ3
  assign scl_fall = scl_p & ~scl_s;
  // captured bit is held a whole clock period, so it is stable here
  assign bit_evt = tog_s ^ tog_p;
  assign byte_in = {shift[BYTE_W-2:0], link_bit}; // RQ4
  assign byte_done = bit_evt & (cnt == LAST_BIT);
  assign slot_done = bit_evt & (cnt == ACK_SLOT);

  // ----------------------------------------------------------------------
  // strap address capture after reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt <= 2'h0;
      own_addr <= DEV_ADDR_BASE;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
      own_addr <= DEV_ADDR_BASE + {5'h00, strap_s}; // RQ8
    end
  end

  // ----------------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ack_now <= 1'b0;
      rw <= 1'b0;
    end else if (start) begin
      state <= ST_ADDR; // RQ2
      cnt <= 4'h0;
      ack_now <= 1'b0;
    end else if (stop) begin
      state <= ST_IDLE; // RQ3
      cnt <= 4'h0;
      ack_now <= 1'b0;
    end else if (bit_evt && state != ST_IDLE && state != ST_IGNORE) begin
      if (cnt != ACK_SLOT) begin
        shift <= byte_in; // RQ4
        cnt <= cnt + 4'h1;
        if (cnt == LAST_BIT) begin
          case (state)
            ST_ADDR: begin
              if (byte_in[BYTE_W-1:1] == own_addr) begin // RQ9
                ack_now <= 1'b1;
                rw <= byte_in[0];
              end else begin
                state <= ST_IGNORE; // RQ15
              end
            end
            ST_PTR: ack_now <= 1'b1; // RQ10
            ST_WDATA: ack_now <= 1'b1; // RQ11 RQ12
            ST_RDATA: ack_now <= 1'b0; // RQ6
            default: ack_now <= 1'b0;
          endcase
        end
      end else begin
        cnt <= 4'h0;
        ack_now <= 1'b0;
        case (state)
          ST_ADDR: state <= rw ? ST_RDATA : ST_PTR; // RQ13
          ST_PTR: state <= ST_WDATA;
          ST_WDATA: state <= ST_WDATA; // RQ11
          ST_RDATA: begin
            // host not-acknowledge ends the read until stop or restart
            if (link_bit) begin
              state <= ST_IGNORE; // RQ6
            end
          end
          default: state <= ST_IGNORE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= '0;
    end else if (!start && !stop) begin
      if (byte_done && state == ST_PTR) begin
        ptr <= byte_in[PTR_W-1:0]; // RQ10
      end else if (byte_done && state == ST_WDATA) begin
        ptr <= ptr + 6'h01; // RQ11
      end else if (slot_done && state == ST_RDATA && !link_bit) begin
        ptr <= ptr + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_wr <= '0;
    end else begin
      reg_wr.valid <= byte_done && state == ST_WDATA && !start && !stop;
      reg_wr.addr <= ptr; // RQ11 RQ12
      reg_wr.data <= byte_in;
    end
  end

  // ----------------------------------------------------------------------
  // data line drive, set only just after the clock falls, released at once on start, stop, idle or ignore
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // RQ16
      if (start || stop || state == ST_IGNORE || state == ST_IDLE) begin
        sda_oe <= 1'b0; // RQ15
      end else if (scl_fall) begin // RQ1
        if (cnt == ACK_SLOT) begin
          sda_oe <= ack_now; // RQ5
        end else if (state == ST_RDATA) begin
          sda_oe <= ~rd_data[3'(BIT_MSB - cnt[2:0])]; // RQ13 RQ16
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock-low shutdown
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pden <= 1'b0;
    end else if (reg_wr.valid && reg_wr.addr == CTRL_ADDR) begin
      pden <= reg_wr.data[PDEN_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
    end else if (!pden || scl_s) begin
      low_cnt <= '0;
    end else if (low_cnt != LOW_CNT_W'(SHDN_CYC)) begin
      low_cnt <= low_cnt + 16'h0001; // RQ14
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shutdown <= 1'b0;
    end else begin
      shutdown <= pden && !scl_s && low_cnt == LOW_CNT_W'(SHDN_CYC); // RQ14
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_drive_clock_low: assert property ( // RQ1
    @(posedge clock) disable iff (!rst_b)
    $rose(sda_oe) |-> !scl_s)
    else $error("data drive started while clock high");

  a_start_to_addr: assert property ( // RQ2
    @(posedge clock) disable iff (!rst_b)
    start |=> (state == ST_ADDR && cnt == 4'h0 && !sda_oe))
    else $error("start did not reopen address phase");

  a_stop_to_idle: assert property ( // RQ3
    @(posedge clock) disable iff (!rst_b)
    (stop && !start) |=> (state == ST_IDLE && !sda_oe))
    else $error("stop did not end the transfer");

  a_bit_count: assert property ( // RQ4
    @(posedge clock) disable iff (!rst_b)
    (bit_evt && !start && !stop && cnt < ACK_SLOT &&
     (state == ST_ADDR || state == ST_PTR || state == ST_WDATA))
    |=> cnt == $past(cnt) + 4'h1)
    else $error("bit counter slipped");

  a_ack_drive: assert property ( // RQ5
    @(posedge clock) disable iff (!rst_b)
    (scl_fall && cnt == ACK_SLOT && ack_now && !start && !stop &&
     state != ST_IDLE && state != ST_IGNORE) |=> sda_oe)
    else $error("accepted byte not acknowledged");

  a_read_no_ack: assert property ( // RQ6
    @(posedge clock) disable iff (!rst_b)
    (scl_fall && cnt == ACK_SLOT && state == ST_RDATA) |=> !sda_oe)
    else $error("device drove the host acknowledge slot");

  a_write_strobe: assert property ( // RQ11
    @(posedge clock) disable iff (!rst_b)
    (byte_done && state == ST_WDATA && !start && !stop)
    |=> (reg_wr.valid && reg_wr.data == $past(byte_in) &&
         ptr == $past(ptr) + 6'h01))
    else $error("write byte not stored at pointer");

  a_foreign_addr: assert property ( // RQ15
    @(posedge clock) disable iff (!rst_b)
    (byte_done && state == ST_ADDR && !start && !stop &&
     byte_in[BYTE_W-1:1] != own_addr)
    |=> (state == ST_IGNORE && !sda_oe) [*2])
    else $error("foreign address not ignored");

  a_low_shutdown: assert property ( // RQ14
    @(posedge clock) disable iff (!rst_b)
    (pden && !scl_s && low_cnt == LOW_CNT_W'(SHDN_CYC)) |=> shutdown)
    else $error("long clock low did not shut down");

endmodule : lrp_port

`default_nettype wire

//--- tb/lrp_host.sv
/*
  lrp_host: behavioural two-wire bus controller facing the LED driver port.
  Assumes a free running link timebase; the line wiring is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none

module lrp_host #(
  parameter int Q = 42
) (
  // link timebase
  input wire logic lclk,
  // bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // idle bus: both lines released, clock stands high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // quarter bit period, four of them keep the rate under 400 kbit/s
  task automatic tick();
    repeat (Q) @(posedge lclk);
  endtask : tick

  task automatic start();
    if (!scl) begin
      sda_pull <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
    end
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start

  task automatic stop();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b0;
    tick();
    tick();
  endtask : stop

  // data set only while the clock is low, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    s = sda;
    tick();
    scl <= 1'b0;
    tick();
  endtask : bit_io

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] b,
                       output logic slot);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(nack, slot);
  endtask : rbyte
endmodule : lrp_host

`default_nettype wire

//--- tb/led_driver_i2c_register_port_test.sv
/*
  led_driver_i2c_register_port_test: self-checking bench of the serial port.
  Assumes lrp_pkg and lrp_host; the shutdown count is shortened to 2 us.
*/
`timescale 1ns/1ps
`default_nettype none

module led_driver_i2c_register_port_test;
  import lrp_pkg::*;
  localparam int unsigned SHDN = 200;
  logic clock, lclk, rst_b, scl_clk, sda_pull, sda_o, sda_oe, shutdown;
  logic sda_wire;
  logic [1:0] addr_strap;
  lrp_reg_wr_t reg_wr;
  logic [13:0] exp_q[$];
  logic [7:0] mem [REG_NUM];
  int mismatches, n_compared, cycles;

  // ----------------------------------------------------------------------
  // clocks, wiring, instances
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #7.5 lclk = ~lclk;
  end
  assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

  lrp_port #(.SHDN_CYC(SHDN)) DUT (.clock(clock), .rst_b(rst_b),
    .scl_clk(scl_clk), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .reg_wr(reg_wr), .shutdown(shutdown));
  lrp_host host (.lclk(lclk), .scl(scl_clk), .sda_pull(sda_pull),
    .sda(sda_wire));

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clock) begin
    if (rst_b === 1'b1 && reg_wr.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare reg_wr", 16'hffff, {2'b0, reg_wr.addr, reg_wr.data});
      end else begin
        check("reg_wr", {2'b0, exp_q.pop_front()},
              {2'b0, reg_wr.addr, reg_wr.data});
      end
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      $display("[FAIL] timeout expected done seen hang");
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------------
  task automatic do_reset(input logic [1:0] s);
    @(posedge clock);
    rst_b <= 1'b0;
    addr_strap <= s;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) @(posedge clock);
    foreach (mem[i]) mem[i] = REG_RESET;
  endtask : do_reset

  task automatic xfer_write(input logic [6:0] dev, input logic [5:0] ptr,
      input int n, input logic [7:0] dmask, input logic [7:0] dset,
      input logic own);
    logic a;
    logic [7:0] d;
    logic [5:0] p;
    p = ptr;
    host.start();
    host.wbyte({dev, 1'b0}, a);
    check("addr ack", {15'b0, ~own}, {15'b0, a});
    d = 8'($urandom);
    d[5:0] = ptr;
    host.wbyte(d, a);
    check("ptr ack", {15'b0, ~own}, {15'b0, a});
    for (int i = 0; i < n; i++) begin
      d = (8'($urandom) & dmask) | dset;
      if (own) begin
        exp_q.push_back({p, d});
        mem[p] = d;
      end
      host.wbyte(d, a);
      check("data ack", {15'b0, ~own}, {15'b0, a});
      p++;
    end
    host.stop();
  endtask : xfer_write

  task automatic xfer_read(input logic [6:0] dev, input logic [5:0] ptr,
                           input int n);
    logic a, s;
    logic [7:0] d;
    logic [5:0] p;
    p = ptr;
    host.start();
    host.wbyte({dev, 1'b0}, a);
    host.wbyte({2'b11, ptr}, a);
    host.start();
    host.wbyte({dev, 1'b1}, a);
    check("read addr ack", 16'h0, {15'b0, a});
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, d, s);
      check("read data", {8'h0, mem[p]}, {8'h0, d});
      check("ack slot", {15'b0, i == n - 1}, {15'b0, s});
      p++;
    end
    host.stop();
  endtask : xfer_read

  task automatic hold_low(input logic e);
    host.start();
    repeat (300) @(posedge lclk);
    @(negedge clock);
    check("shutdown", {15'b0, e}, {15'b0, shutdown});
    host.stop();
    repeat (5) @(posedge clock);
    @(negedge clock);
    check("wake", 16'h0, {15'b0, shutdown});
  endtask : hold_low

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    addr_strap = 2'h0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(32'hbd9a790e));
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      xfer_write(DEV_ADDR_BASE + 7'(s), 6'($urandom), 1, 8'hff, 8'h00,
                 1'b1);
      $display("test strap %0d done", s);
    end
    xfer_write(DEV_ADDR_BASE, 6'h05, 1, 8'hff, 8'h00, 1'b0);
    $display("test foreign address done");
    xfer_write(DEV_ADDR_BASE + 7'h3, 6'h3e, 4, 8'hf7, 8'h00, 1'b1);
    $display("test burst wrap done");
    xfer_read(DEV_ADDR_BASE + 7'h3, 6'h3f, 2);
    $display("test read done");
    hold_low(1'b0);
    xfer_write(DEV_ADDR_BASE + 7'h3, CTRL_ADDR, 1, 8'h00, 8'h08, 1'b1);
    hold_low(1'b1);
    $display("test shutdown done");
    repeat (20) @(posedge clock);
    check("pending writes", 16'h0, 16'(exp_q.size()));
    tally_and_finish();
  end
endmodule : led_driver_i2c_register_port_test

`default_nettype wire
